/* src/fre_engine.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fre_defs.svh"

module fre_engine
	import fre_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic le_n,
	input wire logic kclk,
	input wire logic [`FRE_AW-1:0] addr_in,
	output logic [`FRE_DW-1:0] dq,
	output logic dq_oe_n,
	output logic wait_out,
	output logic wait_oe_n,
	output logic standby,
	output logic [`FRE_AW-1:0] array_addr,
	output logic [1:0] array_space,
	input wire logic [`FRE_DW-1:0] array_rdata
);

	localparam int unsigned IDLE_CYC =
		(`FRE_IDLE_NS + `FRE_CLK_NS - 1) / `FRE_CLK_NS;
	localparam int unsigned RAND_CYC =
		(`FRE_RAND_NS + `FRE_CLK_NS - 1) / `FRE_CLK_NS;
	localparam int unsigned PAGE_CYC =
		(`FRE_PAGE_NS + `FRE_CLK_NS - 1) / `FRE_CLK_NS;

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	fre_pins_type pin_raw;
	fre_pins_type pin_s1;
	fre_pins_type pin_s2;
	fre_pins_type pin_s3;
	logic [15:0] cfg;
	logic [1:0] space;
	logic rsel;
	logic wait_pol;
	logic ce_act;
	logic active_edge;
	logic pin_change;

	assign pin_raw = '{ce_n: ce_n, oe_n: oe_n, le_n: le_n, kclk: kclk,
		addr: addr_in};

	// Two stages before any logic; third stage only for edge detection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1 <= '{ce_n: 1'b1, oe_n: 1'b1, le_n: 1'b1, kclk: 1'b0,
				addr: '0};
			pin_s2 <= '{ce_n: 1'b1, oe_n: 1'b1, le_n: 1'b1, kclk: 1'b0,
				addr: '0};
			pin_s3 <= '{ce_n: 1'b1, oe_n: 1'b1, le_n: 1'b1, kclk: 1'b0,
				addr: '0};
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign rsel = cfg[`FRE_RSEL];
	assign wait_pol = cfg[`FRE_WPOL];
	assign ce_act = !pin_s2.ce_n;
	assign active_edge = cfg[`FRE_EDGE] ? (pin_s2.kclk && !pin_s3.kclk)
		: (!pin_s2.kclk && pin_s3.kclk);
	assign pin_change = (pin_s2.ce_n != pin_s3.ce_n) ||
		(pin_s2.oe_n != pin_s3.oe_n) || (pin_s2.le_n != pin_s3.le_n) ||
		(pin_s2.addr != pin_s3.addr);

	// ------------------------------------------------------------------
	// AHB-Lite slave: zero wait state, always OKAY
	// ------------------------------------------------------------------
	logic wr_pend;
	logic [7:0] wr_addr;
	logic ap_take;
	fre_burst_state_type state;
	logic page_valid;
	logic crossed;

	assign ap_take = hsel && htrans[1] && hready;

	// Write data arrives one cycle after its address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= ap_take && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// Configuration and space registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg <= `FRE_CFG_RESET;
			space <= `FRE_SPACE_RESET;
		end
		else if (wr_pend && wr_addr == `FRE_CFG_ADDR)
			cfg <= hwdata[15:0];
		else if (wr_pend && wr_addr == `FRE_SPACE_ADDR)
			space <= hwdata[1:0];
	end

	// Read data is registered in the address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (ap_take && !hwrite)
		begin
			case (haddr[7:0])
				`FRE_CFG_ADDR: hrdata <= {16'h0000, cfg};
				`FRE_SPACE_ADDR: hrdata <= {30'h0000_0000, space};
				`FRE_STAT_ADDR: hrdata <= {26'h0000_000, crossed,
					page_valid, standby, (state == ST_END),
					(state != ST_IDLE), !pin_s2.oe_n};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Address latch and burst arming
	// ------------------------------------------------------------------
	logic [`FRE_AW-1:0] lat_addr;
	logic [`FRE_AW-1:0] cur_addr;
	logic armed;
	logic start;

	// Latch is transparent while latch enable is low
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lat_addr <= '0;
		else if (!pin_s2.le_n)
			lat_addr <= pin_s2.addr;
	end

	assign cur_addr = pin_s2.le_n ? lat_addr : pin_s2.addr;

	// Armed by whichever of latch or chip enable falls last
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			armed <= 1'b0;
		else if (!ce_act || start)
			armed <= 1'b0;
		else if (!pin_s2.le_n && (pin_s3.le_n || pin_s3.ce_n))
			armed <= 1'b1;
	end

	assign start = armed && active_edge && !rsel && ce_act;

	// ------------------------------------------------------------------
	// Burst address generation
	// ------------------------------------------------------------------
	function automatic logic [`FRE_AW-1:0] word_addr(
		input logic [`FRE_AW-1:0] base,
		input logic [`FRE_AW-1:0] n,
		input logic [15:0] c);
		logic [3:0] mask;
		logic [`FRE_AW-1:0] lin;
		mask = `FRE_MASK_16;
		lin = `FRE_AW'(base + n);
		case (c[`FRE_BL_HI:`FRE_BL_LO])
			`FRE_BL_4: mask = `FRE_MASK_4;
			`FRE_BL_8: mask = `FRE_MASK_8;
			default: mask = `FRE_MASK_16;
		endcase
		if (c[`FRE_WRAP] || c[`FRE_BL_HI:`FRE_BL_LO] == `FRE_BL_CONT)
			word_addr = lin;
		else if (!c[`FRE_ORD])
			word_addr = {base[`FRE_AW-1:4],
				(base[3:0] & ~mask) | ((base[3:0] ^ n[3:0]) & mask)};
		else
			word_addr = {base[`FRE_AW-1:4],
				(base[3:0] & ~mask) | (lin[3:0] & mask)};
	endfunction

	logic [`FRE_AW-1:0] start_addr;
	logic [`FRE_AW-1:0] idx;
	logic [`FRE_AW-1:0] burst_word;
	logic [`FRE_AW-1:0] nw;
	logic [2:0] cnt;
	logic hold_left;
	logic load;
	logic load_q1;
	logic [2:0] lat_val;
	logic [4:0] blen;
	logic finite;
	logic will_end;
	logic will_wait;

	assign nw = word_addr(start_addr, `FRE_AW'(idx + 1'b1), cfg);
	assign finite = cfg[`FRE_BL_HI:`FRE_BL_LO] != `FRE_BL_CONT;
	assign blen = (cfg[`FRE_BL_HI:`FRE_BL_LO] == `FRE_BL_4) ? 5'h04 :
		(cfg[`FRE_BL_HI:`FRE_BL_LO] == `FRE_BL_8) ? 5'h08 : 5'h10;
	assign will_end = finite && (idx[4:0] == 5'(blen - 5'h01));
	assign will_wait = (cfg[`FRE_WRAP] || !finite) && !crossed &&
		(start_addr[1:0] != 2'h0) && (nw[3:0] == `FRE_BND16);
	// Reserved latency codes fall back to the longest latency
	assign lat_val = (cfg[`FRE_LAT_HI:`FRE_LAT_LO] >= `FRE_LAT_MIN &&
		cfg[`FRE_LAT_HI:`FRE_LAT_LO] <= `FRE_LAT_MAX) ?
		cfg[`FRE_LAT_HI:`FRE_LAT_LO] : `FRE_LAT_MAX;

	// Burst sequencer; advances only on active link edges, so a stopped
	// clock suspends it in place
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= ST_IDLE;
			start_addr <= '0;
			idx <= '0;
			burst_word <= '0;
			cnt <= 3'h0;
			hold_left <= 1'b0;
			crossed <= 1'b0;
			load <= 1'b0;
		end
		else
		begin
			load <= 1'b0;
			if (!ce_act || rsel)
				state <= ST_IDLE;
			else if (active_edge)
			begin
				case (state)
					ST_IDLE:
						if (start)
						begin
							start_addr <= cur_addr;
							burst_word <= cur_addr;
							idx <= '0;
							crossed <= 1'b0;
							cnt <= 3'(lat_val - 3'h1);
							state <= ST_LATENCY;
						end
					ST_LATENCY:
						if (cnt == 3'h1)
						begin
							load <= 1'b1;
							hold_left <= cfg[`FRE_HOLD];
							state <= ST_DATA;
						end
						else
							cnt <= 3'(cnt - 3'h1);
					ST_DATA:
						if (hold_left)
							hold_left <= 1'b0;
						else if (will_end)
							state <= ST_END;
						else
						begin
							idx <= `FRE_AW'(idx + 1'b1);
							burst_word <= nw;
							if (nw[3:0] == `FRE_BND16)
								crossed <= 1'b1;
							if (will_wait)
							begin
								cnt <= {1'b0, start_addr[1:0]};
								state <= ST_WSTATE;
							end
							else
							begin
								load <= 1'b1;
								hold_left <= cfg[`FRE_HOLD];
							end
						end
					ST_WSTATE:
						if (cnt == 3'h1)
						begin
							load <= 1'b1;
							hold_left <= cfg[`FRE_HOLD];
							state <= ST_DATA;
						end
						else
							cnt <= 3'(cnt - 3'h1);
					ST_END:
						state <= ST_END;
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Asynchronous page buffer
	// ------------------------------------------------------------------
	logic [`FRE_AW-3:0] page_tag;
	logic [3:0] fetch_cnt;
	logic fill_run;
	logic fill_run_q;
	logic [1:0] fill_idx;
	logic [1:0] fill_q;
	logic [1:0] sel_cnt;
	logic [1:0] word_sel;
	logic miss;
	logic [`FRE_DW-1:0] page_buf [4];

	assign word_sel = pin_s2.addr[1:0];
	// Live address, so a fresh latch is never fetched a cycle late
	assign miss = rsel && ce_act && (fetch_cnt == 4'h0) && !fill_run &&
		!fill_run_q && (!page_valid ||
		cur_addr[`FRE_AW-1:2] != page_tag);

	// Page miss pays the random access time, then fills four words
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			page_tag <= '0;
			page_valid <= 1'b0;
			fetch_cnt <= 4'h0;
			fill_run <= 1'b0;
			fill_idx <= 2'h0;
			fill_run_q <= 1'b0;
			fill_q <= 2'h0;
		end
		else
		begin
			fill_run_q <= fill_run;
			fill_q <= fill_idx;
			// A fill completing with a register write still counts
			if (wr_pend && !(fill_run_q && fill_q == 2'h3))
				page_valid <= 1'b0;
			else if (miss)
			begin
				page_tag <= cur_addr[`FRE_AW-1:2];
				page_valid <= 1'b0;
				fetch_cnt <= 4'(RAND_CYC);
			end
			else if (fetch_cnt != 4'h0)
			begin
				fetch_cnt <= 4'(fetch_cnt - 4'h1);
				fill_run <= (fetch_cnt == 4'h1);
				fill_idx <= 2'h0;
			end
			else if (fill_run)
			begin
				fill_idx <= 2'(fill_idx + 2'h1);
				fill_run <= (fill_idx != 2'h3);
			end
			else if (fill_run_q && fill_q == 2'h3)
				page_valid <= 1'b1;
		end
	end

	// One capture slot per page word
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_page
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					page_buf[gi] <= '0;
				else if (fill_run_q && fill_q == 2'(gi))
					page_buf[gi] <= array_rdata;
			end
		end
	endgenerate

	// In-page word change costs only the short page time
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sel_cnt <= 2'h0;
		else if (word_sel != pin_s3.addr[1:0])
			sel_cnt <= 2'(PAGE_CYC);
		else if (sel_cnt != 2'h0)
			sel_cnt <= 2'(sel_cnt - 2'h1);
	end

	// ------------------------------------------------------------------
	// Array port and data output
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			array_addr <= '0;
			array_space <= `FRE_SPACE_RESET;
			load_q1 <= 1'b0;
		end
		else
		begin
			array_addr <= rsel ? {page_tag, fill_idx} : burst_word;
			array_space <= space;
			load_q1 <= load;
		end
	end

	// Data stays put between loads, so a suspend keeps the word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dq <= '0;
		else if (rsel && page_valid && sel_cnt == 2'h0 &&
			cur_addr[`FRE_AW-1:2] == page_tag)
			dq <= page_buf[word_sel];
		else if (!rsel && load_q1)
			dq <= array_rdata;
	end

	// Output enable gates only the drive, never the sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dq_oe_n <= 1'b1;
			wait_oe_n <= 1'b1;
		end
		else
		begin
			dq_oe_n <= !(ce_act && !pin_s2.oe_n);
			wait_oe_n <= !ce_act;
		end
	end

	// ------------------------------------------------------------------
	// Automatic standby
	// ------------------------------------------------------------------
	logic [3:0] idle_cnt;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			idle_cnt <= 4'h0;
			standby <= 1'b0;
		end
		else if (pin_change || !rsel)
		begin
			idle_cnt <= 4'h0;
			standby <= 1'b0;
		end
		else if (idle_cnt == 4'(IDLE_CYC - 1))
			standby <= 1'b1;
		else
			idle_cnt <= 4'(idle_cnt + 4'h1);
	end

	// ------------------------------------------------------------------
	// Wait generation
	// ------------------------------------------------------------------
	logic next_wait_asrt;
	logic wait_asrt;

	// Early timing flags the coming gap one data cycle ahead
	always_comb
	begin
		next_wait_asrt = 1'b1;
		if (rsel || space != `FRE_SPACE_ARRAY)
			next_wait_asrt = 1'b1;
		else if (state == ST_DATA)
			next_wait_asrt = cfg[`FRE_WTIM] && !hold_left &&
				(will_end || will_wait);
	end

	// Extra stage lines wait up with the data capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wait_asrt <= 1'b1;
			wait_out <= 1'b1;
		end
		else
		begin
			wait_asrt <= next_wait_asrt;
			wait_out <= !(wait_asrt ^ wait_pol);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_async_wait_on: assert property (rsel |=> wait_asrt)
		else $error("wait not asserted in async mode");
	a_nonarray_wait: assert property (
		space != `FRE_SPACE_ARRAY |=> wait_asrt)
		else $error("wait not asserted outside array reads");
	a_wait_pin_pol: assert property (1'b1 |=>
		wait_out == !($past(wait_asrt) ^ $past(wait_pol)))
		else $error("wait pin polarity wrong");
	a_start_latency: assert property (start &&
		state == ST_IDLE |=> state == ST_LATENCY &&
		cnt == 3'(lat_val - 3'h1))
		else $error("burst did not enter latency");
	a_latency_wait: assert property (state == ST_LATENCY &&
		!rsel |=> wait_asrt)
		else $error("wait released during latency");
	a_wstate_count: assert property (
		$rose(state == ST_WSTATE) |->
		cnt == {1'b0, start_addr[1:0]} && cnt != 3'h0)
		else $error("wait state count wrong");
	a_suspend_hold: assert property (
		!active_edge && ce_act && !rsel |=>
		$stable(idx) && $stable(burst_word))
		else $error("burst moved without a clock edge");
	a_wait_drive: assert property (ce_act |=> !wait_oe_n)
		else $error("wait not driven while chip enabled");
	a_standby_idle: assert property (rsel && !pin_change &&
		idle_cnt == 4'(IDLE_CYC - 1) |=> standby)
		else $error("standby not entered after idle");
	a_page_miss_slow: assert property (miss |=>
		fetch_cnt == 4'(RAND_CYC) && !page_valid)
		else $error("page miss skipped random access");

	c_burst_start: cover property (start);
	c_wait_state: cover property (state == ST_WSTATE);
	c_burst_end: cover property (state == ST_END);
	c_page_fill: cover property (fill_run_q && fill_q == 2'h3);

endmodule
`default_nettype wire

/* src/fre_defs.svh */
`ifndef FRE_DEFS_SVH
`define FRE_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define FRE_CFG_ADDR 8'h00
`define FRE_SPACE_ADDR 8'h04
`define FRE_STAT_ADDR 8'h08
`define FRE_CFG_RESET 16'hbfcf
`define FRE_SPACE_RESET 2'h0

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define FRE_RSEL 15
`define FRE_LAT_HI 13
`define FRE_LAT_LO 11
`define FRE_WPOL 10
`define FRE_HOLD 9
`define FRE_WTIM 8
`define FRE_ORD 7
`define FRE_EDGE 6
`define FRE_WRAP 3
`define FRE_BL_HI 2
`define FRE_BL_LO 0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define FRE_BL_4 3'h1
`define FRE_BL_8 3'h2
`define FRE_BL_16 3'h3
`define FRE_BL_CONT 3'h7
`define FRE_MASK_4 4'h3
`define FRE_MASK_8 4'h7
`define FRE_MASK_16 4'hf
`define FRE_LAT_MIN 3'h2
`define FRE_LAT_MAX 3'h5
`define FRE_SPACE_ARRAY 2'h0
`define FRE_BND16 4'h0
`define FRE_AW 22
`define FRE_DW 16

// ----------------------------------------------------------------------
// Timing, in ns
// ----------------------------------------------------------------------
`define FRE_CLK_NS 25
`define FRE_IDLE_NS 150
`define FRE_RAND_NS 70
`define FRE_PAGE_NS 25

`endif

/* src/fre_pkg.sv */
`default_nettype none
`include "fre_defs.svh"

package fre_pkg;

	// Flash bus pins as sampled from the host side
	typedef struct packed
	{
		logic ce_n;
		logic oe_n;
		logic le_n;
		logic kclk;
		logic [`FRE_AW-1:0] addr;
	} fre_pins_type;

	// Synchronous burst sequencing
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_LATENCY,
		ST_DATA,
		ST_WSTATE,
		ST_END
	} fre_burst_state_type;

endpackage
`default_nettype wire

/* verif/fre_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fre_defs.svh"

module fre_host_model
	import fre_pkg::*;
(
	output var fre_pins_type pins
);

	// --------------------------------
	// Host side of the flash bus
	// --------------------------------

	// Deselected bus at time zero, burst clock parked low
	initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 22'h0};

	// Deselect and park the burst clock at its inactive level
	task automatic idle(input int act);
		pins.ce_n = 1'b1;
		pins.oe_n = 1'b1;
		pins.le_n = 1'b1;
		pins.kclk = ~1'(act);
		pins.addr = ~pins.addr; // Released lines must not look stable
		#200;
	endtask

	// Latch a start address, then scramble the released address lines
	task automatic latch(input logic [21:0] a);
		pins.ce_n = 1'b0;
		pins.oe_n = 1'b0;
		pins.addr = a;
		pins.le_n = 1'b0;
		#100;
		pins.le_n = 1'b1;
		#75;
		pins.addr = ~a;
		#25;
	endtask

	// One clock period; the active edge comes first, clock parks after
	task automatic tick();
		pins.kclk = ~pins.kclk;
		#100;
		pins.kclk = ~pins.kclk;
		#100;
	endtask

	// Asynchronous access; low address bits are never gated by le_n
	task automatic drive(input logic [21:0] a, input logic le);
		pins.ce_n = 1'b0;
		pins.oe_n = 1'b0;
		pins.le_n = le;
		pins.addr = a;
	endtask

	// Suspend: chip kept selected, clock already halted, data outputs off
	task automatic pause(input logic on);
		pins.oe_n = on;
	endtask

endmodule
`default_nettype wire

/* verif/fre_engine_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fre_defs.svh"

module fre_engine_tb
	import fre_pkg::*;
;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	fre_pins_type pins;
	logic [15:0] dq;
	logic [15:0] array_rdata;
	logic dq_oe_n;
	logic wait_out;
	logic wait_oe_n;
	logic standby;
	logic [21:0] array_addr;
	logic [21:0] a;
	logic [1:0] array_space;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int exp_q[$];
	// lat, len, seq, nowrap, hold, early, pol, rise, suspend, start, bank
	int tc[16][11] = '{'{2, 1, 1, 0, 0, 0, 1, 1, 99, 1, 0},
		'{3, 1, 0, 0, 0, 0, 1, 1, 99, 3, 0},
		'{4, 2, 1, 0, 0, 0, 1, 1, 99, 6, 0},
		'{5, 2, 0, 0, 0, 0, 1, 1, 99, 5, 0},
		'{3, 3, 1, 0, 0, 0, 1, 1, 99, 9, 0},
		'{2, 3, 0, 0, 0, 0, 1, 1, 99, 7, 0},
		'{2, 1, 1, 1, 0, 0, 1, 1, 99, 13, 0},
		'{3, 2, 1, 1, 0, 0, 1, 1, 99, 14, 0},
		'{4, 3, 1, 1, 0, 0, 1, 1, 99, 3, 0},
		'{2, 2, 1, 1, 0, 0, 1, 1, 99, 0, 0},
		'{3, 7, 1, 1, 0, 1, 1, 1, 99, 2, 0},
		'{2, 7, 1, 0, 0, 0, 1, 1, 99, 12, 1},
		'{2, 1, 1, 0, 1, 0, 1, 1, 99, 2, 0},
		'{3, 2, 1, 0, 0, 0, 0, 0, 99, 5, 0},
		'{4, 1, 1, 0, 0, 0, 1, 1, 1, 1, 0},
		'{2, 3, 1, 1, 0, 0, 1, 1, 6, 1, 0}};

	// --------------------------------
	// Design, host model and array contents
	// --------------------------------

	// Array contents are a fixed scramble of the word address
	function automatic logic [15:0] fdat(input logic [21:0] x);
		return x[15:0] ^ 16'hc3a5;
	endfunction

	assign array_rdata = fdat(array_addr);
	assign hready = hreadyout;

	always #12.5 hclk = ~hclk;

	fre_host_model i_host (.pins(pins));

	fre_engine i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ce_n(pins.ce_n),
		.oe_n(pins.oe_n), .le_n(pins.le_n), .kclk(pins.kclk),
		.addr_in(pins.addr), .dq(dq), .dq_oe_n(dq_oe_n),
		.wait_out(wait_out), .wait_oe_n(wait_oe_n), .standby(standby),
		.array_addr(array_addr), .array_space(array_space),
		.array_rdata(array_rdata));

	// --------------------------------
	// Checking and bus tasks
	// --------------------------------

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single AHB transfer; ends 7 ns after an edge so pins move off edges
	task automatic ahb(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, ad};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rdv = hrdata;
		check({30'h0, hreadyout, hresp}, 32'h2);
		#7;
	endtask

	// Expected word offsets of a burst; -1 marks a wait state
	task automatic build(input int s, input int bl, input int sq,
		input int nw);
		int n;
		int m;
		int w;
		exp_q = {};
		n = (bl == 7) ? 20 : (4 << (bl - 1));
		m = n - 1;
		w = 0;
		for (int i = 0; i < n; i++)
		begin
			if (bl != 7 && nw == 0)
				exp_q.push_back(sq ? ((s & ~m) | ((s + i) & m)) : (s ^ i));
			else
			begin
				if (i > 0 && (s + i) % 16 == 0 && w == 0)
				begin
					repeat (s % 4) exp_q.push_back(-1);
					w = 1;
				end
				exp_q.push_back(s + i);
			end
		end
	endtask

	// One configured burst, sampled just before each following edge
	task automatic burst(input int p[11]);
		int lat;
		int sz;
		int ne;
		int j;
		logic [21:0] base;
		logic ew;
		lat = p[0];
		base = p[10] ? 22'h03fff0 : (22'($urandom) & 22'h3fff00);
		ahb(1'b1, `FRE_CFG_ADDR, {16'h0, 2'b00, 3'(lat), 1'(p[6]),
			1'(p[4]), 1'(p[5]), 1'(p[2]), 1'(p[7]), 2'b00, 1'(p[3]),
			3'(p[1])}, rd);
		build(p[9], p[1], p[2], p[3]);
		sz = exp_q.size();
		ne = lat - 1 + sz * (p[4] + 1) + ((p[1] != 7) ? 2 : 0);
		i_host.idle(p[7]);
		i_host.latch(22'(base + p[9]));
		for (int k = 0; k < ne; k++)
		begin
			i_host.tick();
			j = k - lat + 1;
			if (p[4] != 0 && j > 0)
				j = j / 2;
			ew = (j < 0 || j >= sz || exp_q[j] < 0 ||
				(p[5] != 0 && j + 1 < sz && exp_q[j + 1] < 0));
			check({31'h0, wait_out}, {31'h0, ew ~^ 1'(p[6])});
			if (j >= 0 && j < sz && exp_q[j] >= 0)
				check({dq_oe_n, dq}, {1'b0, fdat(22'(base + exp_q[j]))});
			if (k == p[8])
			begin
				i_host.pause(1'b1);
				#400;
				check({dq_oe_n, wait_oe_n}, 32'h2);
				i_host.pause(1'b0);
				#100;
			end
		end
	endtask

	// --------------------------------
	// Main sequence and hang guard
	// --------------------------------

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			test_done();
		end
	end

	initial
	begin
		void'($urandom(32'h5d36ec01));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		ahb(1'b0, `FRE_CFG_ADDR, 32'h0, rd);
		check(rd, {16'h0, `FRE_CFG_RESET});
		ahb(1'b0, 8'h10, 32'h0, rd);
		check(rd, 32'h0);
		ahb(1'b1, `FRE_SPACE_ADDR, 32'h2, rd);
		ahb(1'b0, `FRE_SPACE_ADDR, 32'h0, rd);
		check(rd, 32'h2);
		check({30'h0, array_space}, 32'h2);
		// Bursts below read only the array space
		ahb(1'b1, `FRE_SPACE_ADDR, 32'h0, rd);
		// Page read: slow miss, fast hits with le_n high, clock ignored
		a = 22'($urandom) & 22'h3ffff8;
		i_host.drive(a, 1'b0);
		#400;
		check({dq_oe_n, dq}, {1'b0, fdat(a)});
		check({31'h0, wait_out}, 32'h1);
		for (int i = 1; i < 4; i++)
		begin
			i_host.drive(a + 22'(i), 1'b1);
			#100;
			check(dq, fdat(a + 22'(i)));
		end
		i_host.tick();
		i_host.tick();
		check(dq, fdat(a + 22'h3));
		#300;
		check({dq_oe_n, standby, dq}, {2'b01, fdat(a + 22'h3)});
		i_host.drive(a + 22'h4, 1'b0);
		#100;
		check({31'h0, dq !== fdat(a + 22'h4)}, 32'h1);
		#300;
		check(dq, fdat(a + 22'h4));
		for (int i = 0; i < 16; i++)
			burst(tc[i]);
		// Last burst crossed 16 words, ended, outputs still enabled
		ahb(1'b0, `FRE_STAT_ADDR, 32'h0, rd);
		check(rd, 32'h27);
		test_done();
	end

endmodule
`default_nettype wire
